// ==== verilog/intc_words_pkg.sv ====
// Purpose: shared constants for the control-word decoder
// Assumes: 8-bit control bytes, one address line
// Notes: field positions are bit indices within a control byte
package intc_words_pkg;

    // ------------------------------------------------------------
    // first initialization word fields
    // ------------------------------------------------------------
    localparam int WORD1_MARK = 4;
    localparam int TRIGGER_SELECT = 3;
    localparam int SPACING_SELECT = 2;
    localparam int SINGLE_FLAG = 1;
    localparam int FOURTH_WORD_REQUEST = 0;

    // ------------------------------------------------------------
    // fourth word and command word fields
    // ------------------------------------------------------------
    localparam int EXTENDED_NESTING_BIT = 4;
    localparam int BUFFER_BIT = 3;
    localparam int BUFFERED_SLAVE_BIT = 2;
    localparam int SELF_FINISH_BIT = 1;
    localparam int VECTOR_BIT = 0;
    localparam int ROTATE_BIT = 7;
    localparam int SPECIFY_LEVEL_BIT = 6;
    localparam int FINISH_BIT = 5;
    localparam int CMD_SELECT = 3;
    localparam int SET_NESTING_BIT = 6;
    localparam int EXCEPTIONAL_NESTING_BIT = 5;
    localparam int POLL_BIT = 2;
    localparam int SET_REGISTER_BIT = 1;
    localparam int READ_SELECT_BIT = 0;

    // ------------------------------------------------------------
    // reset values and answer bytes
    // ------------------------------------------------------------
    localparam logic [2:0] LOWEST_RESET = 3'h7;
    localparam logic [7:0] CALL_OPCODE = 8'hcd;
    localparam logic [7:0] WORD_CLEAR = 8'h00;

    typedef enum logic [2:0] {
        UNINIT = 3'b000,
        EXPECT_TWO = 3'b001,
        EXPECT_THREE = 3'b010,
        EXPECT_FOUR = 3'b011,
        READY = 3'b100
    } init_state_type;

    // priority rank of a level, 0 highest, given the lowest level
    function automatic logic [2:0] rankOf(input logic [2:0] level,
                                          input logic [2:0] lowest);
        rankOf = 3'(level - lowest - 3'h1);
    endfunction

endpackage

// ==== verilog/request_latch.sv ====
// Purpose: request input sampling with edge or level trigger
// Assumes: inputs synchronous to clk
// Notes: a new edge wins over a take in the same cycle, but a restart in that cycle drops it
`timescale 1ns/10ps
module request_latch #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] requestInput,
    input wire logic levelMode,
    input wire logic restart,
    input wire logic [WIDTH-1:0] take,
    output logic [WIDTH-1:0] pending
);
    logic [WIDTH-1:0] previous;
    logic [WIDTH-1:0] next_previous;
    logic [WIDTH-1:0] next_pending;
    logic [WIDTH-1:0] rise;

    always_comb begin
        rise = requestInput & ~previous;
        // restart keeps the input history: a held-high input needs a new rise
        next_previous = requestInput;
        if (levelMode) begin
            next_pending = requestInput;
        end else if (restart) begin
            next_pending = '0; // RQ2
        end else begin
            next_pending = (pending & ~take) | rise; // RQ9
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            previous <= '0;
            pending <= '0;
        end else begin
            previous <= next_previous;
            pending <= next_pending;
        end
    end
endmodule

// ==== verilog/priority_pick.sv ====
// Purpose: pick the highest priority set bit in circular order
// Assumes: lowest names the level of least priority
// Notes: purely combinational
`timescale 1ns/10ps
module priority_pick
    import intc_words_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] candidates,
    input wire logic [2:0] lowest,
    output logic found,
    output logic [2:0] level
);
    logic [2:0] probe;

    always_comb begin
        found = 1'b0;
        level = 3'h0;
        probe = 3'h0;
        // walk from the lowest priority upward, last hit is the best
        for (int i = 0; i < WIDTH; i++) begin
            probe = 3'(lowest - 3'(i));
            if (candidates[probe]) begin
                found = 1'b1;
                level = probe;
            end
        end
    end
endmodule

// ==== verilog/interrupt_ctrl_control_words.sv ====
// Purpose: control-word decoder and initialization sequencer
// Assumes: wrStrobe, rdStrobe and ackStrobe are one-cycle pulses
// Notes: answer bytes appear one cycle after a read or acknowledge strobe
//
// Contract
// RQ1: first-word marker write always restarts initialization
// RQ2: first word clears edges, pending, service, mask; pending follows the inputs instead if level trigger was selected
// RQ3: first word ends exceptional nesting, reads pending
// RQ4: first word restores fourth-word defaults
// RQ5: host writes second word next
// RQ6: third and fourth words follow flags
// RQ7: later words accepted only in sequence
// RQ8: first word field layout decoded
// RQ9: trigger select picks level or rising edge
// RQ10: spacing select gives four or eight bytes
// RQ11: single flag overrides master or slave choice
// RQ12: second word gives high address or vector
// RQ13: master hands marked levels to slaves
// RQ14: slave answers only on matching cascade address
// RQ15: buffer bit chooses role source
// RQ16: fourth word bit four selects nesting
// RQ17: self finish clears service at sequence end
// RQ18: fourth word bit zero selects vector or call
// RQ19: mask blocks pending and exceptional service
// RQ20: priority-finish word field layout decoded
// RQ21: circular priority, rotate moves lowest position
// RQ22: specify level names rotated or finished level
// RQ23: mode control word sets nesting, poll, read
// RQ24: high-address writes routed by init progress
`timescale 1ns/10ps
module interrupt_ctrl_control_words
    import intc_words_pkg::*;
#(
    parameter int LEVELS = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic addr0,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    input wire logic [LEVELS-1:0] requestInput,
    input wire logic ackStrobe,
    output logic intReq,
    input wire logic slaveSelectPin,
    output logic svPinOut,
    output logic svPinOe,
    input wire logic [2:0] cascadeIn,
    output logic [2:0] cascadeOut,
    output logic cascadeOe
);
    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    init_state_type initState, next_initState;
    logic [7:0] wordOne, next_wordOne;
    logic [7:0] wordTwo, next_wordTwo;
    logic [7:0] wordThree, next_wordThree;
    logic [7:0] wordFour, next_wordFour;

    logic writeWordOne;
    logic writeHigh;
    logic writePriority;
    logic writeMode;

    assign writeWordOne = wrStrobe && !addr0 && dataIn[WORD1_MARK]; // RQ1
    assign writeHigh = wrStrobe && addr0;
    assign writePriority = wrStrobe && !addr0 && !dataIn[WORD1_MARK]
        && !dataIn[CMD_SELECT];
    assign writeMode = wrStrobe && !addr0 && !dataIn[WORD1_MARK]
        && dataIn[CMD_SELECT];

    always_comb begin
        next_initState = initState;
        next_wordOne = wordOne;
        next_wordTwo = wordTwo;
        next_wordThree = wordThree;
        next_wordFour = wordFour;
        if (writeWordOne) begin
            next_wordOne = dataIn; // RQ8
            next_wordFour = WORD_CLEAR; // RQ4
            next_initState = EXPECT_TWO; // RQ1
        end else if (writeHigh) begin
            case (initState) // RQ24
                EXPECT_TWO: begin
                    next_wordTwo = dataIn; // RQ12
                    if (!wordOne[SINGLE_FLAG]) begin
                        next_initState = EXPECT_THREE; // RQ6
                    end else if (wordOne[FOURTH_WORD_REQUEST]) begin
                        next_initState = EXPECT_FOUR; // RQ6
                    end else begin
                        next_initState = READY;
                    end
                end
                EXPECT_THREE: begin
                    next_wordThree = dataIn;
                    if (wordOne[FOURTH_WORD_REQUEST]) begin
                        next_initState = EXPECT_FOUR; // RQ6
                    end else begin
                        next_initState = READY;
                    end
                end
                EXPECT_FOUR: begin
                    next_wordFour = dataIn; // RQ16
                    next_initState = READY;
                end
                // high-address writes before the first word change nothing; mask writes leave the init state as is
                default: next_initState = initState; // RQ7
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            initState <= UNINIT;
            wordOne <= WORD_CLEAR;
            wordTwo <= WORD_CLEAR;
            wordThree <= WORD_CLEAR;
            wordFour <= WORD_CLEAR;
        end else begin
            initState <= next_initState;
            wordOne <= next_wordOne;
            wordTwo <= next_wordTwo;
            wordThree <= next_wordThree;
            wordFour <= next_wordFour;
        end
    end

    // ------------------------------------------------------------
    // decoded modes
    // ------------------------------------------------------------
    logic levelMode, spacingFour, singleMode;
    logic extNest, bufMode, selfFinish, vectorMode;
    logic isMaster, isSlave;

    assign levelMode = wordOne[TRIGGER_SELECT]; // RQ9
    assign spacingFour = wordOne[SPACING_SELECT]; // RQ10
    assign singleMode = wordOne[SINGLE_FLAG];
    assign extNest = wordFour[EXTENDED_NESTING_BIT]; // RQ16
    assign bufMode = wordFour[BUFFER_BIT];
    assign selfFinish = wordFour[SELF_FINISH_BIT]; // RQ17
    assign vectorMode = wordFour[VECTOR_BIT]; // RQ18
    // RQ11 RQ15
    assign isMaster = !singleMode && (bufMode
        ? wordFour[BUFFERED_SLAVE_BIT] : slaveSelectPin);
    assign isSlave = !singleMode && !isMaster;

    function automatic logic [7:0] lowAddress(input logic [7:0] w1,
                                              input logic four,
                                              input logic [2:0] lvl);
        if (four) begin
            lowAddress = {w1[7:5], lvl, 2'b00};
        end else begin
            lowAddress = {w1[7:6], lvl, 3'b000};
        end
    endfunction

    // ------------------------------------------------------------
    // requests and priority
    // ------------------------------------------------------------
    logic [LEVELS-1:0] pending;
    logic [LEVELS-1:0] take;
    logic [LEVELS-1:0] inService, next_inService;
    logic [LEVELS-1:0] mask, next_mask;
    logic [LEVELS-1:0] serviceSeen;
    logic [2:0] lowest, next_lowest;
    logic reqFound, srvFound;
    logic [2:0] reqLevel, srvLevel;
    logic accept;

    request_latch #(.WIDTH(LEVELS)) requestStage (
        .clk(clk),
        .reset(reset),
        .requestInput(requestInput),
        .levelMode(levelMode),
        .restart(writeWordOne),
        .take(take),
        .pending(pending)
    );

    logic exceptNest, next_exceptNest;

    // exceptional nesting hides masked levels from the service check
    assign serviceSeen = exceptNest ? (inService & ~mask) : inService;

    priority_pick #(.WIDTH(LEVELS)) requestPick (
        .candidates(pending & ~mask), // RQ19
        .lowest(lowest),
        .found(reqFound),
        .level(reqLevel)
    );

    priority_pick #(.WIDTH(LEVELS)) servicePick (
        .candidates(serviceSeen), // RQ19
        .lowest(lowest),
        .found(srvFound),
        .level(srvLevel)
    );

    // RQ21
    assign accept = reqFound && (initState == READY) && (!srvFound
        || (rankOf(reqLevel, lowest) < rankOf(srvLevel, lowest))
        || (extNest && reqLevel == srvLevel));

    // ------------------------------------------------------------
    // operation state
    // ------------------------------------------------------------
    logic readIsr, next_readIsr;
    logic pollArmed, next_pollArmed;
    logic [1:0] ackCount, next_ackCount;
    logic [2:0] ackLevel, next_ackLevel;
    logic respond;
    logic [7:0] next_dataOut;
    logic next_dataOe, next_intReq, next_svPinOut, next_svPinOe;
    logic [2:0] next_cascadeOut;
    logic next_cascadeOe;
    logic lastPulse;
    logic [2:0] pfLevel;

    // RQ13 RQ14
    assign respond = !(isMaster && wordThree[ackLevel])
        && !(isSlave && cascadeIn != wordThree[2:0]);
    assign lastPulse = vectorMode ? (ackCount == 2'h1) : (ackCount == 2'h2);

    always_comb begin
        next_inService = inService;
        next_mask = mask;
        next_lowest = lowest;
        next_exceptNest = exceptNest;
        next_readIsr = readIsr;
        next_pollArmed = pollArmed;
        next_ackCount = ackCount;
        next_ackLevel = ackLevel;
        next_dataOut = dataOut;
        next_dataOe = 1'b0;
        next_cascadeOut = cascadeOut;
        take = '0;
        pfLevel = srvLevel;
        if (writeWordOne) begin
            next_inService = '0; // RQ2
            next_mask = '0; // RQ2
            next_lowest = LOWEST_RESET; // RQ21
            next_exceptNest = 1'b0; // RQ3
            next_readIsr = 1'b0; // RQ3
            next_pollArmed = 1'b0;
            next_ackCount = 2'h0;
            next_cascadeOut = 3'h0;
        end else if (writeHigh && initState == READY) begin
            next_mask = dataIn; // RQ19
        end else if (writePriority && initState == READY) begin
            // RQ20 RQ22
            if (dataIn[SPECIFY_LEVEL_BIT]) begin
                pfLevel = dataIn[2:0];
            end
            if (dataIn[FINISH_BIT]
                && (dataIn[SPECIFY_LEVEL_BIT] || srvFound)) begin
                next_inService[pfLevel] = 1'b0; // RQ22
            end
            if (dataIn[ROTATE_BIT]
                && (dataIn[SPECIFY_LEVEL_BIT] || srvFound)) begin
                next_lowest = pfLevel; // RQ21
            end
        end else if (writeMode) begin
            if (dataIn[SET_NESTING_BIT]) begin
                next_exceptNest = dataIn[EXCEPTIONAL_NESTING_BIT]; // RQ23
            end
            if (dataIn[SET_REGISTER_BIT]) begin
                next_readIsr = dataIn[READ_SELECT_BIT]; // RQ23
            end
            next_pollArmed = dataIn[POLL_BIT]; // RQ23
        end else if (rdStrobe) begin
            next_dataOe = 1'b1;
            if (pollArmed) begin
                next_dataOut = {reqFound, 4'h0, reqLevel};
                next_pollArmed = 1'b0;
            end else if (addr0) begin
                next_dataOut = mask;
            end else begin
                next_dataOut = readIsr ? inService : pending; // RQ23
            end
        end else if (ackStrobe) begin
            if (ackCount == 2'h0) begin
                next_ackLevel = reqLevel;
                next_inService[reqLevel] = 1'b1;
                take[reqLevel] = 1'b1;
                next_ackCount = 2'h1;
                if (isMaster && wordThree[reqLevel]) begin
                    next_cascadeOut = reqLevel; // RQ13
                end
                if (!vectorMode && respond) begin
                    next_dataOe = !(isMaster && wordThree[reqLevel]);
                    next_dataOut = CALL_OPCODE; // RQ18
                end
            end else begin
                next_dataOe = respond; // RQ14
                if (vectorMode) begin
                    next_dataOut = {wordTwo[7:3], ackLevel}; // RQ12
                end else if (ackCount == 2'h1) begin
                    next_dataOut = lowAddress(wordOne, spacingFour,
                        ackLevel); // RQ10
                end else begin
                    next_dataOut = wordTwo; // RQ12
                end
                next_ackCount = 2'(ackCount + 2'h1);
                if (lastPulse) begin
                    next_ackCount = 2'h0;
                    next_cascadeOut = 3'h0;
                    if (selfFinish) begin
                        next_inService[ackLevel] = 1'b0; // RQ17
                    end
                end
            end
        end
        next_intReq = accept && (ackCount == 2'h0) && !wrStrobe;
        next_svPinOe = bufMode; // RQ15
        next_svPinOut = !(bufMode && next_dataOe);
        next_cascadeOe = !isSlave; // RQ11
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            inService <= '0;
            mask <= '0;
            lowest <= LOWEST_RESET;
            exceptNest <= 1'b0;
            readIsr <= 1'b0;
            pollArmed <= 1'b0;
            ackCount <= 2'h0;
            ackLevel <= 3'h0;
            dataOut <= WORD_CLEAR;
            dataOe <= 1'b0;
            intReq <= 1'b0;
            svPinOut <= 1'b1;
            svPinOe <= 1'b0;
            cascadeOut <= 3'h0;
            cascadeOe <= 1'b0;
        end else begin
            inService <= next_inService;
            mask <= next_mask;
            lowest <= next_lowest;
            exceptNest <= next_exceptNest;
            readIsr <= next_readIsr;
            pollArmed <= next_pollArmed;
            ackCount <= next_ackCount;
            ackLevel <= next_ackLevel;
            dataOut <= next_dataOut;
            dataOe <= next_dataOe;
            intReq <= next_intReq;
            svPinOut <= next_svPinOut;
            svPinOe <= next_svPinOe;
            cascadeOut <= next_cascadeOut;
            cascadeOe <= next_cascadeOe;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_init_restart: assert property (writeWordOne |=> // RQ1
        initState == EXPECT_TWO) else $error("restart not taken");
    a_init_clears: assert property (writeWordOne |=> // RQ2
        inService == '0 && mask == '0)
        else $error("service or mask not cleared");
    a_init_reads: assert property (writeWordOne |=> // RQ3
        !exceptNest && !readIsr) else $error("read select not reset");
    a_four_defaults: assert property (writeWordOne |=> // RQ4
        !extNest && !bufMode && !selfFinish && !vectorMode)
        else $error("fourth word defaults wrong");
    a_word_order: assert property (initState == EXPECT_TWO // RQ6
        && writeHigh |=> initState == (!singleMode ? EXPECT_THREE
        : (wordOne[FOURTH_WORD_REQUEST] ? EXPECT_FOUR : READY)))
        else $error("wrong word after second");
    a_mask_route: assert property (initState == READY && writeHigh // RQ24
        |=> mask == $past(dataIn)) else $error("mask word lost");
    a_rotate_level: assert property (initState == READY // RQ22
        && writePriority && dataIn[ROTATE_BIT] && dataIn[SPECIFY_LEVEL_BIT]
        |=> lowest == $past(dataIn[2:0]))
        else $error("rotate level wrong");
    a_finish_level: assert property (initState == READY // RQ22
        && writePriority && dataIn[FINISH_BIT] && dataIn[SPECIFY_LEVEL_BIT]
        |=> !inService[$past(dataIn[2:0])])
        else $error("finish level not cleared");
    a_slave_quiet: assert property (ackStrobe && ackCount != 2'h0 // RQ14
        && isSlave && cascadeIn != wordThree[2:0] && !writeWordOne
        |=> !dataOe) else $error("slave drove bus on mismatch");
    a_call_opcode: assert property (ackStrobe && ackCount == 2'h0 // RQ18
        && !vectorMode && !wrStrobe && !rdStrobe ##1 dataOe
        |-> dataOut == CALL_OPCODE) else $error("opcode missing");

    c_init_done: cover property (initState == EXPECT_FOUR ##1
        initState == READY);
    c_ack_end: cover property (ackCount == 2'h2 ##1 ackCount == 2'h0);
    c_rotate: cover property (writePriority && dataIn[ROTATE_BIT]);
endmodule

// ==== sim/host_model.sv ====
// Purpose: host processor writing control words and pulsing strobes
// Assumes: one request per call, released a cycle before the next
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/10ps
module host_model
    import intc_words_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    output logic wrStrobe,
    output logic rdStrobe,
    output logic ackStrobe,
    output logic addr0,
    output logic [7:0] dataIn
);
    initial begin
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        ackStrobe = 1'b0;
        addr0 = 1'b0;
        dataIn = 8'h00;
    end

    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge clk);
        wrStrobe <= 1'b1;
        addr0 <= a;
        dataIn <= d;
        @(posedge clk);
        wrStrobe <= 1'b0;
        dataIn <= ~d;
    endtask

    // read when isAck is 0, acknowledge when 1; answer one cycle later
    task automatic pulse(input bit isAck, output logic oe,
                         output logic [7:0] q);
        @(posedge clk);
        if (isAck) ackStrobe <= 1'b1;
        else rdStrobe <= 1'b1;
        addr0 <= 1'b0;
        @(posedge clk);
        ackStrobe <= 1'b0;
        rdStrobe <= 1'b0;
        #1;
        oe = dataOe;
        q = dataOut;
    endtask

    // words go out strictly in sequence, skipped ones as flagged
    task automatic init(input logic [7:0] w1, w2, w4);
        wr(1'b0, w1);
        wr(1'b1, w2);
        if (!w1[SINGLE_FLAG]) wr(1'b1, 8'h00);
        if (w1[FOURTH_WORD_REQUEST]) wr(1'b1, w4);
    endtask
endmodule

// ==== sim/interrupt_ctrl_control_words_tb_top.sv ====
// Purpose: self-checking bench for the control-word decoder
// Assumes: single-device setups, role pin high
// Notes: each pass re-initializes, so state never leaks between passes
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
module interrupt_ctrl_control_words_tb_top;
    import intc_words_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wrStrobe, rdStrobe, ackStrobe, addr0, dataOe, intReq, oe;
    logic [7:0] dataIn, dataOut, q;
    logic casOe, svOe;
    logic [2:0] casOut;
    logic [7:0] req = 8'h00;
    int fails = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    host_model i_host_model(.clk(clk), .dataOut(dataOut),
        .dataOe(dataOe), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .ackStrobe(ackStrobe), .addr0(addr0), .dataIn(dataIn));

    interrupt_ctrl_control_words i_interrupt_ctrl_control_words(
        .clk(clk), .reset(reset), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .addr0(addr0), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .requestInput(req),
        .ackStrobe(ackStrobe), .intReq(intReq), .slaveSelectPin(1'b1),
        .svPinOut(), .svPinOe(svOe), .cascadeIn(3'h0),
        .cascadeOut(casOut), .cascadeOe(casOe));

    function automatic logic [7:0] lowByte(logic [7:0] w1, logic [2:0] l);
        return w1[SPACING_SELECT] ? {w1[7:5], l, 2'b00}
                                  : {w1[7:6], l, 3'b000};
    endfunction

    task automatic test_done();
        $display("Checks %0d, errors %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic waitReq();
        int n;
        n = 0;
        while (intReq !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        `CHK(intReq, 1'b1)
        if (n == 20) test_done();
    endtask

    // ------------------------------------------------------------
    // one pass: init, read pending, mask, acknowledge sequence
    // ------------------------------------------------------------
    task automatic serve(input logic [7:0] w1, w2, w4, input logic [2:0] l);
        logic vec;
        vec = w1[FOURTH_WORD_REQUEST] & w4[VECTOR_BIT];
        i_host_model.init(w1, w2, w4);
        @(posedge clk);
        req <= 8'h01 << l;
        waitReq();
        i_host_model.pulse(1'b0, oe, q);
        `CHK({oe, q}, {1'b1, 8'h01 << l})
        i_host_model.wr(1'b1, 8'h01 << l);
        repeat (3) @(posedge clk);
        `CHK(intReq, 1'b0)
        i_host_model.wr(1'b1, 8'h00);
        waitReq();
        // poll returns the found flag and the best pending level
        i_host_model.wr(1'b0, 8'h0c);
        i_host_model.pulse(1'b0, oe, q);
        `CHK({oe, q}, {1'b1, 1'b1, 4'h0, l})
        i_host_model.pulse(1'b1, oe, q);
        req <= 8'h00;
        if (vec) begin
            `CHK(oe, 1'b0)
            i_host_model.pulse(1'b1, oe, q);
            `CHK({oe, q}, {1'b1, w2[7:3], l})
        end else begin
            `CHK({oe, q}, {1'b1, CALL_OPCODE})
            i_host_model.pulse(1'b1, oe, q);
            `CHK(q, lowByte(w1, l))
            i_host_model.pulse(1'b1, oe, q);
            `CHK(q, w2)
        end
        `CHK({casOe, svOe, casOut}, 5'b10000)
        // read the in-service register, then finish the named level
        i_host_model.wr(1'b0, 8'h0b);
        i_host_model.pulse(1'b0, oe, q);
        `CHK({oe, q}, {1'b1, 8'h01 << l})
        i_host_model.wr(1'b0, {5'b01100, l});
        i_host_model.pulse(1'b0, oe, q);
        `CHK({oe, q}, {1'b1, 8'h00})
    endtask

    initial begin
        logic [7:0] r;
        void'($urandom(91));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        i_host_model.wr(1'b1, 8'hff);
        i_host_model.wr(1'b0, 8'h13);
        serve(8'hb7, 8'h12, 8'h00, 3'h7);
        serve(8'h53, 8'hf8, 8'h01, 3'h0);
        serve(8'h1a, 8'h40, 8'h01, 3'h5);
        for (int i = 0; i < 12; i++) begin
            r = 8'($urandom);
            serve({r[7:5], 1'b1, r[3:2], 1'b1, r[0]}, 8'($urandom),
                  {7'h00, r[4]}, 3'($urandom));
        end
        test_done();
    end
endmodule
